// File: logic/hs_port_defines.vh
// Purpose: Constants for the high-speed host port timing block
// Assumes: clk_sys at 25 MHz; one clock per symbol on the line interface
// Notes: Times in their own unit, counts derived from the clock rate
// Notes on behaviour
// - Own packets open with 32-bit sync
// - Reply gap 8 to 192 bit times; rx_end is unused, so no reply is timed from a received packet
// - Back-to-back host packets gap 8 to 192
// - Non-SOF EOP is one unstuffed 8-bit byte
// - SOF EOP is 40 unstuffed bits
// - Answer device chirp with three or more KJ pairs
// - Start host chirps within 100 us
// - Each host chirp lasts 40 to 60 us
// - First SOF 100 to 500 us after chirps
// - SOF every 125 us after enumeration
// - Suspend stops SOF and idles bus
// - Resume bit cleared ends resume signalling
// - SOF restarts within 3 ms of idle
`ifndef HS_PORT_DEFINES_VH
`define HS_PORT_DEFINES_VH
`define CLK_MHZ 25
`define SYNC_BITS 8'd32
`define GAP_BITS 8'd16
`define EOP_BITS 8'd8
`define SOF_EOP_BITS 8'd40
`define CHIRP_PAIRS 3'd3
`define CHIRP_RESP_US 2
`define CHIRP_US 50
`define SOF_FIRST_US 200
`define SOF_PERIOD_US 125
`define SOF_BYTE 8'hA5
`define BIT_LAST 3'h7
`define CYC(us) ((us) * `CLK_MHZ)
`define CHIRP_RESP_CYC `CYC(`CHIRP_RESP_US)
`define CHIRP_CYC `CYC(`CHIRP_US)
`define SOF_FIRST_CYC `CYC(`SOF_FIRST_US)
`define SOF_PERIOD_CYC `CYC(`SOF_PERIOD_US)
`define LS_IDLE 2'h0
`define LS_J 2'h1
`define LS_K 2'h2
`define LS_SE0 2'h3
`endif

// File: logic/word_fifo.v
// Purpose: Small flip-flop FIFO with valid and ready on both sides
// Assumes: Depth is a power of two
// Notes: Full and empty come from a fill count
`timescale 1ns/1ns
`default_nettype none
module word_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 8,
	parameter AW = 3
) (
	// Clock and reset
	input wire clk_sys,
	input wire rst_n,
	// Fill side
	input wire in_valid,
	input wire [WIDTH-1:0] in_data,
	output wire in_ready,
	// Drain side
	output wire out_valid,
	output wire [WIDTH-1:0] out_data,
	input wire out_ready
);
	reg [WIDTH-1:0] mem_q [0:DEPTH-1];
	reg [AW-1:0] wr_q;
	reg [AW-1:0] rd_q;
	reg [AW:0] cnt_q;
	wire push;
	wire pop;
	assign in_ready = (cnt_q != DEPTH[AW:0]);
	assign out_valid = (cnt_q != {(AW+1){1'b0}});
	assign out_data = mem_q[rd_q];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	always @(posedge clk_sys) begin
		if (push)
			mem_q[wr_q] <= in_data;
		if (!rst_n) begin
			wr_q <= {AW{1'b0}};
			rd_q <= {AW{1'b0}};
			cnt_q <= {(AW+1){1'b0}};
		end else begin
			if (push)
				wr_q <= wr_q + 1'b1;
			if (pop)
				rd_q <= rd_q + 1'b1;
			if (push && !pop)
				cnt_q <= cnt_q + 1'b1;
			else if (pop && !push)
				cnt_q <= cnt_q - 1'b1;
		end
	end
endmodule // word_fifo
`default_nettype wire

// File: logic/hs_host_port_timing.v
// Purpose: Host port link framing, chirp handshake, SOF and suspend
// Assumes: One symbol per clock; line state coded as J, K, SE0, idle
// Notes: Packet bytes pass a FIFO; each byte goes out as eight symbols
`timescale 1ns/1ns
`default_nettype none
`include "hs_port_defines.vh"
module hs_host_port_timing #(
	parameter FIFO_DEPTH = 8,
	parameter CHIRP_RESP_CYC = `CHIRP_RESP_CYC,
	parameter CHIRP_CYC = `CHIRP_CYC,
	parameter SOF_FIRST_CYC = `SOF_FIRST_CYC,
	parameter SOF_PERIOD_CYC = `SOF_PERIOD_CYC
) (
	// Clock and reset
	input wire clk_sys,
	input wire rst_n,
	// Firmware control
	input wire bus_reset,
	input wire enum_done,
	input wire suspend,
	input wire resume,
	// Packet source: bytes, last marks end of packet
	input wire pkt_valid,
	input wire [7:0] pkt_data,
	input wire pkt_last,
	output wire pkt_ready,
	// Reply request: end of a received packet; not used by the logic
	input wire rx_end,
	// Line from the device
	input wire dev_chirp_k,
	// Line to the device
	output reg [1:0] line_state,
	output reg line_oe,
	output reg sof_pulse,
	output reg hs_mode
);
	localparam S_IDLE = 9'h001;
	localparam S_WAITCH = 9'h002;
	localparam S_CHIRP = 9'h004;
	localparam S_HSIDLE = 9'h008;
	localparam S_GAP = 9'h010;
	localparam S_SYNC = 9'h020;
	localparam S_DATA = 9'h040;
	localparam S_EOP = 9'h080;
	localparam S_RESUME = 9'h100;
	reg [8:0] st_q;
	reg [8:0] st_d;
	reg [15:0] tmr_q;
	reg [15:0] sof_q;
	reg [7:0] bit_q;
	reg [2:0] pairs_q;
	reg chirp_j_q;
	reg sof_pend_q;
	reg is_sof_q;
	reg last_q;
	reg [7:0] sh_q;
	reg dev_k_q;
	reg [7:0] sh_d;
	reg last_d;
	wire chirp_end;
	wire f_valid;
	wire [8:0] f_data;
	wire f_ready;
	wire sof_due;
	// Pop exactly when a FIFO byte moves into the shifter; the SOF byte is loaded without a pop
	assign f_ready = !is_sof_q && ((st_q == S_SYNC && st_d == S_DATA) ||
		(st_q == S_DATA && bit_q[2:0] == `BIT_LAST && !last_q));
	word_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH), .AW(3)) u_fifo (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.in_valid(pkt_valid),
		.in_data({pkt_last, pkt_data}),
		.in_ready(pkt_ready),
		.out_valid(f_valid),
		.out_data(f_data),
		.out_ready(f_ready)
	);
	assign sof_due = sof_q == SOF_PERIOD_CYC[15:0] - 16'd1;
	// Each chirp lasts exactly CHIRP_CYC clocks
	assign chirp_end = tmr_q == CHIRP_CYC[15:0] - 16'd1;
	// Next shifter contents, so the line shows the bit now loaded
	always @* begin
		sh_d = sh_q;
		last_d = last_q;
		if (st_q == S_SYNC && st_d == S_DATA) begin
			sh_d = is_sof_q ? `SOF_BYTE : f_data[7:0];
			last_d = is_sof_q | f_data[8];
		end else if (st_q == S_DATA && bit_q[2:0] == `BIT_LAST &&
			!last_q) begin
			sh_d = f_data[7:0];
			last_d = f_data[8];
		end else if (st_q == S_DATA)
			sh_d = {1'b0, sh_q[7:1]};
	end
	always @* begin
		st_d = st_q;
		case (st_q)
		S_IDLE: if (bus_reset && dev_k_q && !dev_chirp_k)
			st_d = S_WAITCH;
		S_WAITCH: if (tmr_q == CHIRP_RESP_CYC[15:0]) st_d = S_CHIRP;
		S_CHIRP: if (chirp_end && chirp_j_q &&
			pairs_q == `CHIRP_PAIRS - 3'd1)
			st_d = S_HSIDLE;
		S_HSIDLE: if (resume) st_d = S_RESUME;
			else if (!suspend && !sof_pend_q && f_valid)
				st_d = S_GAP;
			else if (!suspend && sof_pend_q)
				st_d = S_GAP;
		S_GAP: if (suspend) st_d = S_HSIDLE;
			else if (bit_q == `GAP_BITS) st_d = S_SYNC;
		S_SYNC: if (bit_q == `SYNC_BITS - 8'd1) st_d = S_DATA;
		S_DATA: if (bit_q[2:0] == `BIT_LAST && last_q) st_d = S_EOP;
		S_EOP: if (bit_q == (is_sof_q ? `SOF_EOP_BITS : `EOP_BITS) - 8'd1)
			st_d = S_HSIDLE;
		S_RESUME: if (!resume) st_d = S_HSIDLE;
		default: st_d = S_IDLE;
		endcase
		if (!bus_reset && st_q == S_IDLE) st_d = S_IDLE;
	end
	always @(posedge clk_sys) begin
		if (!rst_n) begin
			st_q <= S_IDLE;
			tmr_q <= 16'h0000;
			sof_q <= 16'h0000;
			bit_q <= 8'h00;
			pairs_q <= 3'h0;
			chirp_j_q <= 1'b0;
			sof_pend_q <= 1'b0;
			is_sof_q <= 1'b0;
			last_q <= 1'b0;
			sh_q <= 8'h00;
			dev_k_q <= 1'b0;
			line_state <= `LS_IDLE;
			line_oe <= 1'b0;
			sof_pulse <= 1'b0;
			hs_mode <= 1'b0;
		end else begin
			st_q <= st_d;
			dev_k_q <= dev_chirp_k;
			sof_pulse <= 1'b0;
			bit_q <= (st_d != st_q) ? 8'h00 : bit_q + 8'h01;
			// Chirp timing
			if (st_q == S_CHIRP && chirp_end) begin
				tmr_q <= 16'h0000;
				chirp_j_q <= !chirp_j_q;
				if (chirp_j_q)
					pairs_q <= pairs_q + 3'd1;
			end else if (st_d != st_q && st_q != S_HSIDLE)
				tmr_q <= 16'h0000;
			else if (st_q == S_WAITCH || st_q == S_CHIRP)
				tmr_q <= tmr_q + 16'h0001;
			if (st_q == S_CHIRP && st_d == S_HSIDLE)
				hs_mode <= 1'b1;
			// Microframe timer, first SOF delayed after chirps
			if (st_q == S_IDLE || st_q == S_CHIRP)
				sof_q <= SOF_PERIOD_CYC[15:0] - SOF_FIRST_CYC[15:0];
			else if (suspend || st_q == S_RESUME)
				sof_q <= 16'h0000;
			else if (sof_due)
				sof_q <= 16'h0000;
			else
				sof_q <= sof_q + 16'h0001;
			if (sof_due && enum_done && !suspend && !resume)
				sof_pend_q <= 1'b1;
			else if (st_q == S_HSIDLE && st_d == S_GAP)
				sof_pend_q <= 1'b0;
			if (st_q == S_HSIDLE && st_d == S_GAP)
				is_sof_q <= sof_pend_q;
			if (st_d == S_SYNC && st_q == S_GAP && is_sof_q)
				sof_pulse <= 1'b1;
			// Byte loading
			sh_q <= sh_d;
			last_q <= last_d;
			// Line drive
			line_oe <= (st_d != S_IDLE && st_d != S_HSIDLE &&
				st_d != S_GAP && st_d != S_WAITCH);
			case (st_d)
			S_CHIRP: line_state <= (chirp_j_q ^
				(st_q == S_CHIRP && chirp_end))
				? `LS_J : `LS_K;
			S_SYNC: line_state <= (bit_q[0] && st_q == S_SYNC) ?
				`LS_J : `LS_K;
			S_DATA: line_state <= sh_d[0] ? `LS_J : `LS_K;
			S_EOP: line_state <= `LS_SE0;
			S_RESUME: line_state <= `LS_K;
			default: line_state <= `LS_IDLE;
			endcase
		end
	end
endmodule // hs_host_port_timing
`default_nettype wire

// File: verif/hs_dev_model.sv
// Purpose: Attached device, chirp side of the handshake
// Assumes: Chirp follows the start of bus reset
// Notes: Delay and length are parameters
`timescale 1ns/1ns
`default_nettype none
module hs_dev_model #(parameter DLY = 10, parameter LEN = 30) (
	// Clock and bus reset
	input wire logic clk_sys,
	input wire logic bus_reset,
	// Chirp to host
	output var logic dev_chirp_k
);
	int n = 0;
	initial dev_chirp_k = 1'b0;
	// One chirp K per bus reset, then release
	always @(negedge clk_sys) begin
		n <= bus_reset ? n + 1 : 0;
		dev_chirp_k <= bus_reset && n >= DLY && n < DLY + LEN;
	end
endmodule // hs_dev_model
`default_nettype wire

// File: verif/hs_host_port_timing_assertions.sv
// Purpose: Line timing checks on the host port
// Assumes: One symbol per clock
// Notes: A run counter measures symbol lengths
`timescale 1ns/1ns
`default_nettype none
module hs_port_checker #(parameter CHIRP_CYC = 20) (
	// Clock and control
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic bus_reset,
	input wire logic suspend,
	input wire logic resume,
	input wire logic dev_chirp_k,
	// Line
	input wire logic [1:0] line_state,
	input wire logic line_oe,
	input wire logic sof_pulse,
	input wire logic hs_mode
);
	logic [2:0] prev_q;
	int run_q;
	wire logic chg = {line_oe, line_state} != prev_q;
	always @(posedge clk_sys) begin
		prev_q <= {line_oe, line_state};
		run_q <= (!rst_n || chg) ? 1 : run_q + 1;
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	sequence s_eop_end;
		chg && prev_q == 3'h7 && !bus_reset;
	endsequence
	sequence s_chirp_end;
		chg && bus_reset && prev_q inside {3'h5, 3'h6};
	endsequence
	sequence s_gap_end;
		chg && prev_q == 3'h0 && hs_mode && !resume;
	endsequence
	sequence s_res_hold;
		resume [*3];
	endsequence
	chk_susp_quiet: assert property (
		suspend && $past(suspend) |-> !sof_pulse) else $error("sof in suspend");
	chk_res_quiet: assert property (
		resume |-> !sof_pulse) else $error("sof in resume");
	chk_res_drive: assert property (
		s_res_hold |-> line_oe && line_state == 2'h2) else $error("no resume K");
	chk_res_end: assert property (
		$fell(resume) |-> ##[1:3] !(line_oe && line_state == 2'h2))
		else $error("resume K stays");
	chk_eop_len: assert property (
		s_eop_end |-> run_q == 8 || run_q == 40) else $error("bad eop length");
	chk_chirp_len: assert property (
		s_chirp_end |-> run_q == CHIRP_CYC) else $error("bad chirp length");
	chk_gap_min: assert property (
		s_gap_end |-> run_q >= 8) else $error("gap too short");
	chk_chirp_resp: assert property (
		$fell(dev_chirp_k) && bus_reset |-> ##[1:1000] line_oe && line_state == 2'h2)
		else $error("late chirp reply");
endmodule // hs_port_checker
bind hs_host_port_timing hs_port_checker #(.CHIRP_CYC(CHIRP_CYC)) u_chk (
	.clk_sys(clk_sys), .rst_n(rst_n), .bus_reset(bus_reset),
	.suspend(suspend), .resume(resume), .dev_chirp_k(dev_chirp_k),
	.line_state(line_state), .line_oe(line_oe), .sof_pulse(sof_pulse),
	.hs_mode(hs_mode));
`default_nettype wire

// File: verif/tb_top.sv
// Purpose: Self-checking bench for the host port
// Assumes: Scaled chirp and SOF counts
// Notes: Model counts symbols per packet
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	localparam int CH = 20, SF = 120, SP = 300;
	logic clk_sys = 0, rst_n = 0, bus_reset = 0, enum_done = 0;
	logic suspend = 0, resume = 0, pkt_valid = 0, pkt_last = 0;
	logic [7:0] pkt_data = 8'h00;
	wire logic pkt_ready, dev_chirp_k, line_oe, sof_pulse, hs_mode;
	wire logic [1:0] line_state;
	int fail_count = 0, cmp_count = 0, cyc = 0, kj = 0, se = 0, gap = 0;
	int t_hs = 0, t_sof = 0, chirps = 0, nsof = 0, n0 = 0, lo = SF - 2;
	int hi = SF + 20;
	int q_len[$];
	bit sofp = 0, pend = 0;
	logic [1:0] ls_p = 2'h0;
	always #20 clk_sys = ~clk_sys;
	hs_host_port_timing #(.CHIRP_CYC(CH), .SOF_FIRST_CYC(SF),
		.SOF_PERIOD_CYC(SP)) dut (.clk_sys(clk_sys), .rst_n(rst_n),
		.bus_reset(bus_reset), .enum_done(enum_done), .suspend(suspend),
		.resume(resume), .pkt_valid(pkt_valid), .pkt_data(pkt_data),
		.pkt_last(pkt_last), .pkt_ready(pkt_ready), .rx_end(1'b0),
		.dev_chirp_k(dev_chirp_k), .line_state(line_state),
		.line_oe(line_oe), .sof_pulse(sof_pulse), .hs_mode(hs_mode));
	hs_dev_model dev (.clk_sys(clk_sys), .bus_reset(bus_reset),
		.dev_chirp_k(dev_chirp_k));
	task automatic chk(string n, logic [31:0] s, logic [31:0] e);
		cmp_count++;
		if (s !== e) begin
			fail_count++;
			$display("[ERR] %s exp %0d got %0d", n, e, s);
		end
	endtask
	task automatic wrap_up;
		if (fail_count == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic send(int n);
		q_len.push_back(n);
		for (int i = 0; i < n; i++) begin
			pkt_valid = 1;
			pkt_data = 8'($urandom);
			pkt_last = i == n - 1;
			for (int w = 0; w < 3000 && !pkt_ready; w++) @(negedge clk_sys);
			@(negedge clk_sys);
		end
		pkt_valid = 0;
	endtask
	// Line monitor and packet model
	always @(negedge clk_sys) begin
		cyc++;
		if (bus_reset && ls_p == 2'h2 && line_state == 2'h1) chirps++;
		ls_p = line_state;
		if (sof_pulse) begin
			nsof++;
			sofp = 1;
			if (t_sof == 0) chk("sof delay", (cyc - t_hs) inside {[lo:hi]}, 1);
			else chk("sof period", cyc - t_sof, SP);
			t_sof = cyc;
		end
		if (hs_mode && !resume && !bus_reset) begin
			if (line_oe && line_state == 2'h3) se++;
			else if (line_oe) begin
				if (gap > 0 && pend) chk("gap", gap >= 8 && gap <= 192, 1);
				gap = 0;
				kj++;
			end else if (se > 0) begin
				chk("eop", se, sofp ? 40 : 8);
				chk("body", kj, 32 + 8 * (sofp ? 1 : q_len.pop_front()));
				pend = q_len.size() > 0;
				{se, kj, sofp} = 0;
				gap = 1;
			end else begin
				gap++;
				kj = 0;
			end
		end
	end
	initial begin
		void'($urandom(26370));
		repeat (20) @(negedge clk_sys);
		rst_n = 1;
		bus_reset = 1;
		for (int i = 0; i < 2000 && !hs_mode; i++) @(negedge clk_sys);
		chk("chirp pairs", chirps >= 3, 1);
		chk("hs mode", hs_mode, 1);
		t_hs = cyc;
		bus_reset = 0;
		enum_done = 1;
		repeat (3) begin
			@(posedge sof_pulse);
			@(negedge clk_sys);
			send($urandom_range(4, 1));
		end
		repeat (900) @(negedge clk_sys);
		suspend = 1;
		repeat (50) @(negedge clk_sys);
		n0 = nsof;
		send(8);
		chk("fifo full", pkt_ready, 0);
		repeat (150) @(negedge clk_sys);
		chk("suspend sof", nsof, n0);
		suspend = 0;
		resume = 1;
		repeat (100) @(negedge clk_sys);
		chk("resume sof", nsof, n0);
		resume = 0;
		{t_hs, t_sof, lo, hi} = {cyc, 0, 1, SP + 40};
		repeat (800) @(negedge clk_sys);
		chk("queue left", q_len.size(), 0);
		wrap_up;
	end
	initial begin
		#(40 * 8000);
		fail_count++;
		wrap_up;
	end
endmodule // tb_top
`default_nettype wire
